// *** src/iap_cfg.svh ***
`ifndef IAP_CFG_SVH
`define IAP_CFG_SVH

// ----------------------------------------------------------------
// Register bus
// ----------------------------------------------------------------
`define IAP_AXI_AW 12
`define IAP_RESP_OKAY 2'h0
`define IAP_RESP_SLVERR 2'h2

// ----------------------------------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------------------------------
`define IAP_IDX_ANA_CTRL 8'h40
`define IAP_IDX_ANA_OFF 8'h41
`define IAP_IDX_ANA_VAL 8'h42
`define IAP_IDX_BUS_CTRL 8'h48
`define IAP_IDX_ADDR_LO 8'h49
`define IAP_IDX_ADDR_HI 8'h4a
`define IAP_IDX_BYTE0 8'h4b
`define IAP_IDX_BYTE1 8'h4c
`define IAP_IDX_BYTE2 8'h4d
`define IAP_IDX_BYTE3 8'h4e
`define IAP_IDX_NONE 8'hff

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define IAP_ANA_SEL_MSB 4
`define IAP_ANA_SEL_LSB 2
`define IAP_ANA_STEP_BIT 1
`define IAP_ANA_DIR_BIT 0
`define IAP_BUS_SEL_MSB 4
`define IAP_BUS_SEL_LSB 3
`define IAP_BUS_STEP_BIT 2
`define IAP_BUS_RD_BIT 1
`define IAP_BUS_EN_BIT 0

// ----------------------------------------------------------------
// Codes, steps and reset values
// ----------------------------------------------------------------
`define IAP_ANA_RX 3'h4
`define IAP_ANA_TX 3'h5
`define IAP_BUS_RXC 2'h0
`define IAP_ANA_INC 8'h01
`define IAP_STEP_RXC 16'h0004
`define IAP_STEP_OTHER 16'h0001
`define IAP_RST_REG 8'h00

`endif

// *** src/iap_pkg.sv ***
`include "iap_cfg.svh"
`default_nettype none

package iap_pkg;

  typedef enum logic [1:0] {
    S_IDLE = 2'h0,
    S_ANA = 2'h1,
    S_RRSP = 2'h3,
    S_WRSP = 2'h2
  } iap_st_t;

  typedef enum logic [1:0] {
    P_IDLE = 2'h0,
    P_SETUP = 2'h1,
    P_ACCESS = 2'h3
  } iap_pst_t;

  typedef struct packed {
    iap_st_t st;
    logic awready;
    logic wready;
    logic arready;
    logic bvalid;
    logic rvalid;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_got;
    logic w_got;
    logic [`IAP_AXI_AW-1:0] waddr;
    logic [7:0] wdata;
    logic wen;
    logic [2:0] ana_sel;
    logic ana_step;
    logic ana_dir;
    logic [7:0] ana_off;
    logic [7:0] ana_val;
    logic ana_req;
    logic ana_wr;
    logic [1:0] bus_sel;
    logic bus_step;
    logic bus_rd;
    logic bus_en;
    logic [15:0] bus_addr;
    logic [31:0] bus_word;
    logic bus_wr_pend;
    logic bus_act;
    logic bus_opwr;
  } iap_top_st_t;

  typedef struct packed {
    iap_pst_t st;
    logic psel;
    logic penable;
    logic pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
    logic [1:0] ptarget;
    logic done;
    logic [31:0] rdata;
  } iap_mst_st_t;

endpackage

`default_nettype wire

// *** src/iap_bus_if.sv ***
`default_nettype none

interface iap_bus_if;
  logic req;
  logic wr;
  logic [1:0] target;
  logic [15:0] addr;
  logic [31:0] wdata;
  logic done;
  logic [31:0] rdata;

  modport ctrl (output req, wr, target, addr, wdata, input done, rdata);
  modport mst (input req, wr, target, addr, wdata, output done, rdata);
endinterface

`default_nettype wire

// *** src/iap_apb_mst.sv ***
`include "iap_cfg.svh"
`default_nettype none

module iap_apb_mst (
  input wire logic clk,
  input wire logic rst,
  iap_bus_if.mst bus,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [15:0] paddr,
  output logic [31:0] pwdata,
  output logic [1:0] ptarget,
  input wire logic [31:0] prdata,
  input wire logic pready
);

  iap_pkg::iap_mst_st_t s;
  iap_pkg::iap_mst_st_t n;

  // ----------------------------------------------------------------
  // Transfer sequencer
  // ----------------------------------------------------------------
  // Request fields are latched at the request so that software may
  // reprogram the port while a transfer is on the bus.
  always_comb begin
    n = s;
    n.done = 1'b0;
    case (s.st)
      iap_pkg::P_IDLE: begin
        if (bus.req) begin
          n.psel = 1'b1;
          n.pwrite = bus.wr;
          n.paddr = bus.addr;
          n.pwdata = bus.wdata;
          n.ptarget = bus.target;
          n.st = iap_pkg::P_SETUP;
        end
      end
      iap_pkg::P_SETUP: begin
        n.penable = 1'b1;
        n.st = iap_pkg::P_ACCESS;
      end
      iap_pkg::P_ACCESS: begin
        if (pready) begin
          n.psel = 1'b0;
          n.penable = 1'b0;
          n.done = 1'b1;
          if (!s.pwrite) begin
            n.rdata = prdata;
          end
          n.st = iap_pkg::P_IDLE;
        end
      end
      default: begin
        n.st = iap_pkg::P_IDLE;
      end
    endcase
    if (rst) begin
      n = '0;
    end
  end

  always_ff @(posedge clk) begin
    s <= n;
  end

  assign psel = s.psel;
  assign penable = s.penable;
  assign pwrite = s.pwrite;
  assign paddr = s.paddr;
  assign pwdata = s.pwdata;
  assign ptarget = s.ptarget;
  assign bus.done = s.done;
  assign bus.rdata = s.rdata;

endmodule // iap_apb_mst

`default_nettype wire

// *** src/iap_top.sv ***
// Behaviour
// - Analog target 000 off, 100 receiver, 101 transmitter, others reserved.
// - Analog offset steps by one after each completed indirect access.
// - Direction bit 0 makes value accesses writes, 1 makes them reads.
// - An 8-bit offset addresses the register inside the analog block.
// - Writing the value register launches an indirect write of the byte.
// - Reading the value register returns the selected analog register.
// - Bus target 00 controller, 01 SRAM, 10 config, 11 die identity.
// - Bus auto-increment steps by 4 for controller, 1 for others.
// - Read-start bit begins a bus read, fills bytes, self-clears.
// - Bus transfers only while enabled; target follows the target field.
// - Bus address is 16 bits, low byte and high byte registers.
// - Data word bytes 0 and 1 are readable and writable registers.
// - Data word bytes 2 and 3 complete the 32-bit transfer value.
`include "iap_cfg.svh"
`default_nettype none

module iap_top (
  input wire logic REF_CLK,
  input wire logic RST,
  // AXI4-Lite register slave
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [`IAP_AXI_AW-1:0] AWADDR,
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [`IAP_AXI_AW-1:0] ARADDR,
  output logic RVALID,
  input wire logic RREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  // Analog register blocks
  output logic ANA_REQ,
  output logic ANA_WRITE,
  output logic ANA_TARGET,
  output logic [7:0] ANA_OFFSET,
  output logic [7:0] ANA_WDATA,
  input wire logic [7:0] ANA_RDATA,
  input wire logic ANA_ACK,
  // Peripheral bus master
  output logic PSEL,
  output logic PENABLE,
  output logic PWRITE,
  output logic [15:0] PADDR,
  output logic [31:0] PWDATA,
  output logic [1:0] BUS_TARGET,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY
);

  iap_pkg::iap_top_st_t s;
  iap_pkg::iap_top_st_t n;
  iap_bus_if bus_if ();
  logic wr_ok;
  logic launch;

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  // Addresses above the register window fold onto an unmapped index.
  function automatic logic [7:0] reg_idx(
    input logic [`IAP_AXI_AW-1:0] a
  );
    logic [7:0] idx;
    idx = `IAP_IDX_NONE;
    if (a[`IAP_AXI_AW-1:10] == '0) begin
      idx = a[9:2];
    end
    return idx;
  endfunction

  function automatic logic is_reg(input logic [7:0] idx);
    logic hit;
    hit = 1'b0;
    case (idx)
      `IAP_IDX_ANA_CTRL, `IAP_IDX_ANA_OFF, `IAP_IDX_ANA_VAL,
      `IAP_IDX_BUS_CTRL, `IAP_IDX_ADDR_LO, `IAP_IDX_ADDR_HI,
      `IAP_IDX_BYTE0, `IAP_IDX_BYTE1, `IAP_IDX_BYTE2,
      `IAP_IDX_BYTE3: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction

  // Only the two documented block codes reach an analog block
  function automatic logic ana_ok(input logic [2:0] sel);
    return (sel == `IAP_ANA_RX) || (sel == `IAP_ANA_TX);
  endfunction

  function automatic logic [15:0] bus_inc(input logic [1:0] sel);
    logic [15:0] step;
    step = `IAP_STEP_OTHER;
    if (sel == `IAP_BUS_RXC) begin
      step = `IAP_STEP_RXC;
    end
    return step;
  endfunction

  function automatic iap_pkg::iap_top_st_t put_ana_ctrl(
    input iap_pkg::iap_top_st_t r,
    input logic [7:0] d
  );
    iap_pkg::iap_top_st_t q;
    q = r;
    q.ana_sel = d[`IAP_ANA_SEL_MSB:`IAP_ANA_SEL_LSB];
    q.ana_step = d[`IAP_ANA_STEP_BIT];
    q.ana_dir = d[`IAP_ANA_DIR_BIT];
    return q;
  endfunction

  // The read-start bit is only ever set here, so a completing read in
  // the same cycle cannot swallow a new start.
  function automatic iap_pkg::iap_top_st_t put_bus_ctrl(
    input iap_pkg::iap_top_st_t r,
    input logic [7:0] d
  );
    iap_pkg::iap_top_st_t q;
    q = r;
    q.bus_sel = d[`IAP_BUS_SEL_MSB:`IAP_BUS_SEL_LSB];
    q.bus_step = d[`IAP_BUS_STEP_BIT];
    q.bus_rd = r.bus_rd | d[`IAP_BUS_RD_BIT];
    q.bus_en = d[`IAP_BUS_EN_BIT];
    return q;
  endfunction

  function automatic logic [7:0] reg_read(
    input iap_pkg::iap_top_st_t r,
    input logic [7:0] idx
  );
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      `IAP_IDX_ANA_CTRL: v = {3'h0, r.ana_sel, r.ana_step, r.ana_dir};
      `IAP_IDX_ANA_OFF: v = r.ana_off;
      `IAP_IDX_ANA_VAL: v = ana_ok(r.ana_sel) ? r.ana_val : 8'h00;
      `IAP_IDX_BUS_CTRL: begin
        v = {3'h0, r.bus_sel, r.bus_step, r.bus_rd, r.bus_en};
      end
      `IAP_IDX_ADDR_LO: v = r.bus_addr[7:0];
      `IAP_IDX_ADDR_HI: v = r.bus_addr[15:8];
      `IAP_IDX_BYTE0: v = r.bus_word[7:0];
      `IAP_IDX_BYTE1: v = r.bus_word[15:8];
      `IAP_IDX_BYTE2: v = r.bus_word[23:16];
      `IAP_IDX_BYTE3: v = r.bus_word[31:24];
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------
  // Peripheral bus launch
  // ----------------------------------------------------------------
  // A pending write to a read-only target is dropped at launch as well,
  // in case the target field changed after the write was posted.
  assign wr_ok = s.bus_wr_pend && !s.bus_sel[1];
  assign launch = !s.bus_act && s.bus_en && (wr_ok || s.bus_rd);
  assign bus_if.req = launch;
  assign bus_if.wr = wr_ok;
  assign bus_if.target = s.bus_sel;
  assign bus_if.addr = s.bus_addr;
  assign bus_if.wdata = s.bus_word;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] idx;
    idx = `IAP_IDX_NONE;
    n = s;
    n.awready = 1'b0;
    n.wready = 1'b0;
    n.arready = 1'b0;

    // Channel capture; ready is a one-cycle pulse per item
    if (s.awready && AWVALID) begin
      n.aw_got = 1'b1;
      n.waddr = AWADDR;
    end
    if (s.wready && WVALID) begin
      n.w_got = 1'b1;
      n.wdata = WDATA[7:0];
      n.wen = WSTRB[0];
    end
    if (s.st == iap_pkg::S_IDLE) begin
      n.awready = !s.aw_got && !s.awready && AWVALID;
      n.wready = !s.w_got && !s.wready && WVALID;
      // Writes go first; a read waits until no write is in flight
      n.arready = !s.arready && ARVALID && !AWVALID && !WVALID &&
                  !s.aw_got && !s.w_got && !s.awready && !s.wready;
    end

    // Peripheral bus completion comes before software writes
    if (bus_if.done) begin
      n.bus_act = 1'b0;
      if (s.bus_opwr) begin
        n.bus_wr_pend = 1'b0;
      end else begin
        n.bus_word = bus_if.rdata;
        n.bus_rd = 1'b0;
      end
      if (s.bus_step) begin
        n.bus_addr = s.bus_addr + bus_inc(s.bus_sel);
      end
    end else if (launch) begin
      n.bus_act = 1'b1;
      n.bus_opwr = wr_ok;
    end else if (!s.bus_act && s.bus_wr_pend && s.bus_sel[1]) begin
      n.bus_wr_pend = 1'b0;
    end

    case (s.st)
      iap_pkg::S_IDLE: begin
        if (s.aw_got && s.w_got) begin
          n.aw_got = 1'b0;
          n.w_got = 1'b0;
          idx = reg_idx(s.waddr);
          n.bresp = is_reg(idx) ? `IAP_RESP_OKAY : `IAP_RESP_SLVERR;
          if (s.wen) begin
            case (idx)
              `IAP_IDX_ANA_CTRL: n = put_ana_ctrl(n, s.wdata);
              `IAP_IDX_ANA_OFF: n.ana_off = s.wdata;
              `IAP_IDX_ANA_VAL: n.ana_val = s.wdata;
              `IAP_IDX_BUS_CTRL: n = put_bus_ctrl(n, s.wdata);
              `IAP_IDX_ADDR_LO: n.bus_addr[7:0] = s.wdata;
              `IAP_IDX_ADDR_HI: n.bus_addr[15:8] = s.wdata;
              `IAP_IDX_BYTE0: n.bus_word[7:0] = s.wdata;
              `IAP_IDX_BYTE1: n.bus_word[15:8] = s.wdata;
              `IAP_IDX_BYTE2: n.bus_word[23:16] = s.wdata;
              `IAP_IDX_BYTE3: begin
                n.bus_word[31:24] = s.wdata;
                // Top byte posts the word; read-only targets never get it
                if (s.bus_en && !s.bus_sel[1]) begin
                  n.bus_wr_pend = 1'b1;
                end
              end
              default: n.bresp = `IAP_RESP_SLVERR;
            endcase
          end
          if (s.wen && idx == `IAP_IDX_ANA_VAL && !s.ana_dir &&
              ana_ok(s.ana_sel)) begin
            n.ana_req = 1'b1;
            n.ana_wr = 1'b1;
            n.st = iap_pkg::S_ANA;
          end else begin
            n.bvalid = 1'b1;
            n.st = iap_pkg::S_WRSP;
          end
        end else if (s.arready && ARVALID) begin
          idx = reg_idx(ARADDR);
          if (idx == `IAP_IDX_ANA_VAL && s.ana_dir &&
              ana_ok(s.ana_sel)) begin
            n.ana_req = 1'b1;
            n.ana_wr = 1'b0;
            n.st = iap_pkg::S_ANA;
          end else begin
            n.rdata = {24'h000000, reg_read(s, idx)};
            n.rresp = is_reg(idx) ? `IAP_RESP_OKAY : `IAP_RESP_SLVERR;
            n.rvalid = 1'b1;
            n.st = iap_pkg::S_RRSP;
          end
        end
      end
      iap_pkg::S_ANA: begin
        // The bus answer is held back until the analog block acknowledges
        if (ANA_ACK) begin
          n.ana_req = 1'b0;
          if (s.ana_step) begin
            n.ana_off = s.ana_off + `IAP_ANA_INC;
          end
          if (s.ana_wr) begin
            n.bresp = `IAP_RESP_OKAY;
            n.bvalid = 1'b1;
            n.st = iap_pkg::S_WRSP;
          end else begin
            n.ana_val = ANA_RDATA;
            n.rdata = {24'h000000, ANA_RDATA};
            n.rresp = `IAP_RESP_OKAY;
            n.rvalid = 1'b1;
            n.st = iap_pkg::S_RRSP;
          end
        end
      end
      iap_pkg::S_WRSP: begin
        if (BREADY) begin
          n.bvalid = 1'b0;
          n.st = iap_pkg::S_IDLE;
        end
      end
      iap_pkg::S_RRSP: begin
        if (RREADY) begin
          n.rvalid = 1'b0;
          n.st = iap_pkg::S_IDLE;
        end
      end
      default: begin
        n.st = iap_pkg::S_IDLE;
      end
    endcase

    if (RST) begin
      n = '0;
      n = put_ana_ctrl(n, `IAP_RST_REG);
      n = put_bus_ctrl(n, `IAP_RST_REG);
      n.ana_off = `IAP_RST_REG;
      n.ana_val = `IAP_RST_REG;
      n.bus_addr = {`IAP_RST_REG, `IAP_RST_REG};
      n.bus_word = {4{`IAP_RST_REG}};
    end
  end

  always_ff @(posedge REF_CLK) begin
    s <= n;
  end

  // ----------------------------------------------------------------
  // Peripheral bus master
  // ----------------------------------------------------------------
  iap_apb_mst u_mst (
    .clk(REF_CLK),
    .rst(RST),
    .bus(bus_if.mst),
    .psel(PSEL),
    .penable(PENABLE),
    .pwrite(PWRITE),
    .paddr(PADDR),
    .pwdata(PWDATA),
    .ptarget(BUS_TARGET),
    .prdata(PRDATA),
    .pready(PREADY)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign AWREADY = s.awready;
  assign WREADY = s.wready;
  assign BVALID = s.bvalid;
  assign BRESP = s.bresp;
  assign ARREADY = s.arready;
  assign RVALID = s.rvalid;
  assign RDATA = s.rdata;
  assign RRESP = s.rresp;
  assign ANA_REQ = s.ana_req;
  assign ANA_WRITE = s.ana_wr;
  assign ANA_TARGET = s.ana_sel[0];
  assign ANA_OFFSET = s.ana_off;
  assign ANA_WDATA = s.ana_val;

endmodule // iap_top

`default_nettype wire

// *** testbench/iap_top_sva.sv ***
`include "iap_cfg.svh"
`default_nettype none

module iap_top_sva (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic [1:0] BRESP,
  input wire logic RVALID,
  input wire logic RREADY,
  input wire logic [31:0] RDATA,
  input wire logic ANA_REQ,
  input wire logic ANA_ACK,
  input wire logic ANA_WRITE,
  input wire logic [7:0] ANA_OFFSET,
  input wire logic [7:0] ANA_WDATA,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [15:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  input wire logic [1:0] BUS_TARGET
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  // ----------------------------------------------------------------
  // Responses and indirect ports
  // ----------------------------------------------------------------
  a_bresp_hold: assert property (
    BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response not held");
  a_rdata_hold: assert property (
    RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data not held");
  a_rdata_byte: assert property (
    RVALID |-> RDATA[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_ana_hold: assert property (
    ANA_REQ && !ANA_ACK |=> ANA_REQ &&
      $stable({ANA_WRITE, ANA_OFFSET, ANA_WDATA}))
    else $error("analog request changed before ack");
  a_ana_answer: assert property (
    ANA_REQ && ANA_ACK |=> !ANA_REQ && (BVALID || RVALID))
    else $error("analog ack not answered");
  a_apb_access: assert property (
    PSEL && !PENABLE |=> PSEL && PENABLE && $stable(PADDR))
    else $error("setup not followed by access");
  a_apb_wait: assert property (
    PENABLE && !PREADY |=> PENABLE &&
      $stable({PADDR, PWRITE, PWDATA, BUS_TARGET}))
    else $error("bus transfer changed while waiting");
  a_apb_close: assert property (
    PENABLE && PREADY |=> !PSEL && !PENABLE)
    else $error("bus transfer not closed");
  a_ro_nowrite: assert property (
    PSEL |-> !(PWRITE && BUS_TARGET[1]))
    else $error("write to read-only target");

  c_bus_read: cover property (PENABLE && PREADY && !PWRITE);
  c_ana_write: cover property (ANA_REQ && ANA_ACK && ANA_WRITE);
  c_slverr: cover property (BVALID && BRESP == `IAP_RESP_SLVERR);
endmodule // iap_top_sva

bind iap_top iap_top_sva u_sva (.REF_CLK, .RST, .BVALID, .BREADY, .BRESP,
  .RVALID, .RREADY, .RDATA, .ANA_REQ, .ANA_ACK, .ANA_WRITE, .ANA_OFFSET,
  .ANA_WDATA, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PREADY,
  .BUS_TARGET);

`default_nettype wire

// *** testbench/iap_far_model.sv ***
`default_nettype none

module iap_far_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] wait_cyc,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [1:0] target,
  output logic [31:0] prdata,
  output logic pready,
  input wire logic ana_req,
  input wire logic ana_write,
  input wire logic ana_target,
  input wire logic [7:0] ana_offset,
  input wire logic [7:0] ana_wdata,
  output logic [7:0] ana_rdata,
  output logic ana_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [logic [17:0]];
  logic [7:0] amem [2][256];
  logic [3:0] pw, aw;
  int wr_cnt, rd_cnt, ana_wr_cnt;

  initial begin
    {prdata, pready, ana_rdata, ana_ack, pw, aw} = '0;
    {wr_cnt, rd_cnt, ana_wr_cnt} = '0;
    for (int i = 0; i < 256; i++) begin
      amem[0][i] = 8'(i) ^ 8'h3c;
      amem[1][i] = 8'(i) ^ 8'hc3;
    end
  end

  // ----------------------------------------------------------------
  // Far side responders
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    pready <= 1'b0;
    ana_ack <= 1'b0;
    // Released lines never keep the last answer
    prdata <= ~prdata;
    ana_rdata <= ~ana_rdata;
    if (rst) begin
      pw <= 4'h0;
      aw <= 4'h0;
    end else begin
      if (psel && penable && !pready) begin
        pw <= (pw == wait_cyc) ? 4'h0 : pw + 4'h1;
        if (pw == wait_cyc) begin
          pready <= 1'b1;
          if (pwrite) begin
            mem[{target, paddr}] = pwdata;
            wr_cnt++;
          end else begin
            prdata <= mem.exists({target, paddr}) ? mem[{target, paddr}]
              : {6'h17, target, paddr, ~paddr[7:0]};
            rd_cnt++;
          end
        end
      end
      if (ana_req && !ana_ack) begin
        aw <= (aw == wait_cyc) ? 4'h0 : aw + 4'h1;
        if (aw == wait_cyc) begin
          ana_ack <= 1'b1;
          if (ana_write) begin
            amem[ana_target][ana_offset] = ana_wdata;
            ana_wr_cnt++;
          end else begin
            ana_rdata <= amem[ana_target][ana_offset];
          end
        end
      end
    end
  end
endmodule // iap_far_model

`default_nettype wire

// *** testbench/tb_indirect_register_access_ports.sv ***
`include "iap_cfg.svh"
`default_nettype none

module tb_indirect_register_access_ports;
  timeunit 1ns;
  timeprecision 1ps;
  logic REF_CLK, RST, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, ANA_REQ, ANA_WRITE;
  logic ANA_TARGET, ANA_ACK, PSEL, PENABLE, PWRITE, PREADY;
  logic [`IAP_AXI_AW-1:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, PWDATA, PRDATA, d, w;
  logic [3:0] WSTRB, far_wait;
  logic [1:0] BRESP, RRESP, BUS_TARGET, rs;
  logic [7:0] ANA_OFFSET, ANA_WDATA, ANA_RDATA;
  logic [15:0] PADDR;
  logic [7:0] regs [10] = '{8'h40, 8'h41, 8'h42, 8'h48, 8'h49, 8'h4a,
    8'h4b, 8'h4c, 8'h4d, 8'h4e};
  int fail_count, cmp_count, n;

  iap_top uut (.REF_CLK, .RST, .AWVALID, .AWREADY, .AWADDR, .WVALID,
    .WREADY, .WDATA, .WSTRB, .BVALID, .BREADY, .BRESP, .ARVALID, .ARREADY,
    .ARADDR, .RVALID, .RREADY, .RDATA, .RRESP, .ANA_REQ, .ANA_WRITE,
    .ANA_TARGET, .ANA_OFFSET, .ANA_WDATA, .ANA_RDATA, .ANA_ACK, .PSEL,
    .PENABLE, .PWRITE, .PADDR, .PWDATA, .BUS_TARGET, .PRDATA, .PREADY);

  iap_far_model far (.clk(REF_CLK), .rst(RST), .wait_cyc(far_wait),
    .psel(PSEL), .penable(PENABLE), .pwrite(PWRITE), .paddr(PADDR),
    .pwdata(PWDATA), .target(BUS_TARGET), .prdata(PRDATA), .pready(PREADY),
    .ana_req(ANA_REQ), .ana_write(ANA_WRITE), .ana_target(ANA_TARGET),
    .ana_offset(ANA_OFFSET), .ana_wdata(ANA_WDATA), .ana_rdata(ANA_RDATA),
    .ana_ack(ANA_ACK));

  initial begin
    REF_CLK = 1'b0;
    forever #5 REF_CLK = ~REF_CLK;
  end

  // ----------------------------------------------------------------
  // Register bus tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    logic done;
    done = 1'b0;
    @(posedge REF_CLK);
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    AWADDR <= {2'h0, idx, 2'h0};
    WDATA <= {24'h0, v};
    while (!done) begin
      @(posedge REF_CLK);
      if (AWREADY === 1'b1) AWVALID <= 1'b0;
      if (WREADY === 1'b1) WVALID <= 1'b0;
      if (BVALID === 1'b1) begin
        rs = BRESP;
        BREADY <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic rd(input logic [7:0] idx);
    logic done;
    done = 1'b0;
    @(posedge REF_CLK);
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    ARADDR <= {2'h0, idx, 2'h0};
    while (!done) begin
      @(posedge REF_CLK);
      if (ARREADY === 1'b1) ARVALID <= 1'b0;
      if (RVALID === 1'b1) begin
        d = RDATA;
        rs = RRESP;
        RREADY <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_rd(input logic [7:0] idx, input logic [31:0] e);
    rd(idx);
    chk($sformatf("reg %h", idx), e, d);
  endtask

  // Bounded poll: the start bit must drop once the far side answers
  task automatic wait_rd();
    for (int i = 0; i < 40; i++) begin
      rd(8'h48);
      if (d[1] === 1'b0) break;
    end
  endtask

  task automatic wrap_up();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #200000;
    fail_count++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {AWVALID, WVALID, BREADY, ARVALID, RREADY} = '0;
    {AWADDR, ARADDR, WDATA} = '0;
    WSTRB = 4'hf;
    far_wait = 4'h2;
    {fail_count, cmp_count} = '0;
    RST = 1'b1;
    repeat (3) @(posedge REF_CLK);
    RST <= 1'b0;
    for (int i = 0; i < 10; i++) chk_rd(regs[i], 32'h0);
    WSTRB <= 4'he;
    wr(8'h41, 8'h55);
    WSTRB <= 4'hf;
    chk_rd(8'h41, 32'h00);
    rd(8'h43);
    chk("unmapped read", {30'h0, `IAP_RESP_SLVERR}, {30'h0, rs});
    wr(8'h44, 8'h01);
    chk("unmapped write", {30'h0, `IAP_RESP_SLVERR}, {30'h0, rs});
    wr(8'h40, 8'h12);
    wr(8'h41, 8'hff);
    wr(8'h42, 8'h5a);
    chk("ana write", 32'h5a, {24'h0, far.amem[0][255]});
    chk_rd(8'h41, 32'h00);
    wr(8'h41, 8'h07);
    for (int s = 0; s < 8; s++) begin
      wr(8'h40, {3'h0, 3'(s), 2'h1});
      w = (s == 4) ? 32'h07 ^ 32'h3c : (s == 5) ? 32'h07 ^ 32'hc3 : 32'h0;
      chk_rd(8'h42, w);
    end
    chk_rd(8'h41, 32'h07);
    wr(8'h40, 8'h17);
    chk_rd(8'h42, 32'h07 ^ 32'hc3);
    chk_rd(8'h41, 32'h08);
    n = far.ana_wr_cnt;
    wr(8'h40, 8'h00);
    wr(8'h42, 8'h99);
    chk("ana blocked", n, far.ana_wr_cnt);
    far_wait <= 4'h0;
    for (int t = 0; t < 4; t++) begin
      wr(8'h49, 8'hfc);
      wr(8'h4a, 8'h12);
      wr(8'h48, {3'h0, 2'(t), 3'h7});
      wait_rd();
      chk("start bit", 32'h0, {31'h0, d[1]});
      w = {6'h17, 2'(t), 16'h12fc, 8'h03};
      for (int b = 0; b < 4; b++)
        chk_rd(8'h4b + 8'(b), {24'h0, w[8*b +: 8]});
      chk_rd(8'h49, (t == 0) ? 32'h00 : 32'hfd);
      chk_rd(8'h4a, (t == 0) ? 32'h13 : 32'h12);
    end
    far_wait <= 4'h3;
    wr(8'h48, 8'h09);
    wr(8'h49, 8'h34);
    wr(8'h4a, 8'h56);
    n = far.wr_cnt;
    for (int b = 0; b < 4; b++) wr(8'h4b + 8'(b), 8'(8'h11 * (b + 1)));
    for (int i = 0; i < 60 && far.wr_cnt == n; i++) @(posedge REF_CLK);
    chk("bus write", 32'h44332211, far.mem[{2'h1, 16'h5634}]);
    wr(8'h48, 8'h11);
    n = far.wr_cnt;
    wr(8'h4e, 8'h77);
    repeat (20) @(posedge REF_CLK);
    chk("ro write", n, far.wr_cnt);
    n = far.rd_cnt;
    wr(8'h48, 8'h02);
    repeat (20) @(posedge REF_CLK);
    chk("idle bus", n, far.rd_cnt);
    chk_rd(8'h48, 32'h02);
    wr(8'h48, 8'h03);
    wait_rd();
    chk("late read", n + 1, far.rd_cnt);
    wrap_up();
  end
endmodule // tb_indirect_register_access_ports

`default_nettype wire
